// ---- logic/dac_device.sv ----
`timescale 1ns/1ps
// Behaviour
// - bridge interrupt disabled after reset
// - bit 6 enables pci interrupt
// - bit 2 reads add-on interrupt flag
// - host writes ones to bits 1:0
// - offset 20h digital out/in
// - offset 30h result with channel tag
// - status gain and timer outputs
// - status bit 1 single-ended jumper
// - status bit 0 low while converting
// - write 1Ch issues one trigger in general mode
// - host paces software triggers
// - read 1Ch clears add-on interrupt
// - converted channel masked to 5 or 4 bits; chanSel unmasked
// - gain uses low two bits
// - channel and gain reset to zero
// - bits 4:2 choose interrupt source
// - bits 1:0 choose trigger method
// - no software trigger while timer runs
// - one trigger per external falling edge
// - pre-trigger runs timer 1 until edge
// - post-trigger holds timer 1 until edge
// - trigger method resets to general
module dac_device
	import dac_pkg::*;
#(
	parameter int CONV_CYC = CONV_CYCLES
)
(
	input wire logic clk,
	input wire logic rst_b,
	dac_io_if.device bus,
	input wire logic singleEnded,
	input wire logic extTrig,
	input wire logic tmr0Out,
	input wire logic tmr1Out,
	input wire logic tmr2Out,
	input wire logic testBit,
	input wire logic [15:0] digIn,
	input wire logic [RES_BITS-1:0] adcData,
	output logic [15:0] digOut,
	output logic [4:0] chanSel,
	output logic [1:0] gainSel,
	output logic convStart,
	output logic tmr1Gate,
	output logic [7:0] timerAddr,
	output logic [7:0] timerWdata,
	output logic timerWr
);
	initial
	begin
		if (CONV_CYC < 1 || CONV_CYC > 65535)
			$error("conversion cycle count out of range");
	end

	logic [31:0] bic_q; // bridge interrupt control
	logic [4:0] chan_q; // channel select
	logic [1:0] gain_q; // gain select
	logic [2:0] src_q; // interrupt source
	logic [1:0] mode_q; // trigger method
	logic [15:0] dout_q; // digital output latch
	logic [15:0] result_q; // tagged result
	logic addonIrq_q; // pending add-on request
	logic busy_q; // conversion running
	logic [15:0] convCnt_q; // conversion timer
	logic [4:0] convChan_q; // channel being converted
	logic armed_q; // pre/post waiting for external edge
	logic trig_q; // registered trigger pulse
	logic gate_q; // timer 1 gate
	logic [31:0] rdata_q; // read data
	logic irqOut_q; // pci interrupt pin, active low
	logic [7:0] tAddr_q; // timer passthrough
	logic [7:0] tData_q;
	logic tWr_q;
	logic extFall, tmr0Fall, tmr1Fall; // edge pulses
	logic wrHit, rdHit; // decoded strobes
	logic trigNow; // trigger condition this cycle
	logic convDone; // last cycle of conversion
	logic srcEvent; // selected interrupt event
	logic [7:0] status; // live status byte
	logic [4:0] chanEff; // channel after masking

	dac_fall_det uExt (.clk(clk), .rst_b(rst_b), .level(extTrig),
		.fall(extFall));
	dac_fall_det uT0 (.clk(clk), .rst_b(rst_b), .level(tmr0Out),
		.fall(tmr0Fall));
	dac_fall_det uT1 (.clk(clk), .rst_b(rst_b), .level(tmr1Out),
		.fall(tmr1Fall));

	assign wrHit = bus.wr;
	assign rdHit = bus.rd;
	assign chanEff = singleEnded ? chan_q : {1'b0, chan_q[3:0]};
	always_comb
	begin
		status = 8'h00;
		status[ST_GAIN_LSB +: 2] = gain_q;
		status[ST_TMR1_BIT] = tmr1Out;
		status[ST_TMR0_BIT] = tmr0Out;
		status[ST_TMR2_BIT] = tmr2Out;
		status[2] = testBit;
		status[ST_SINGLE_BIT] = singleEnded;
		status[ST_IDLE_BIT] = ~busy_q;
	end

	// trigger source per method; software only counts in general mode
	always_comb
	begin
		trigNow = 1'b0;
		case (mode_q)
			MODE_GENERAL: trigNow = tmr0Fall |
				(wrHit && bus.addr == OFS_TRIG_CLR);
			MODE_EXTERNAL: trigNow = extFall;
			MODE_PRE: trigNow = gate_q & tmr1Fall;
			MODE_POST: trigNow = gate_q & tmr1Fall;
			default: trigNow = 1'b0;
		endcase
	end

	always_comb
	begin
		case (src_q)
			SRC_CONV: srcEvent = convDone;
			SRC_TMR0: srcEvent = tmr0Fall;
			SRC_EXT: srcEvent = extFall;
			SRC_TMR1: srcEvent = tmr1Fall;
			default: srcEvent = 1'b0;
		endcase
	end

	assign convDone = busy_q && convCnt_q == 16'(CONV_CYC - 1);

	// control registers written by the host
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			bic_q <= BIC_RESET;
			chan_q <= 5'h00;
			gain_q <= 2'h0;
			src_q <= SRC_NONE;
			mode_q <= MODE_GENERAL;
			dout_q <= 16'h0000;
		end
		else if (wrHit)
		begin
			if (bus.addr == OFS_BRIDGE_IRQ)
				// enable bit and bits 1:0 stored; flag is read-only
				bic_q <= {25'h0, bus.wdata[BIC_ENABLE_BIT], 4'h0,
					bus.wdata[1:0]};
			else if (bus.addr == OFS_CHAN_STATUS)
				chan_q <= bus.wdata[4:0];
			else if (bus.addr == OFS_GAIN)
				gain_q <= bus.wdata[1:0];
			else if (bus.addr == OFS_GEN_CTRL)
			begin
				src_q <= bus.wdata[GC_SRC_LSB +: 3];
				mode_q <= bus.wdata[GC_MODE_LSB +: 2];
			end
			else if (bus.addr == OFS_DIGIO)
				dout_q <= bus.wdata[15:0];
		end
	end

	// pre/post arming: any write to the method field restarts it
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			armed_q <= 1'b0;
			gate_q <= 1'b0;
		end
		else if (wrHit && bus.addr == OFS_GEN_CTRL)
		begin
			armed_q <= bus.wdata[1];
			gate_q <= bus.wdata[1:0] == MODE_PRE;
		end
		else if (armed_q && extFall)
		begin
			armed_q <= 1'b0;
			gate_q <= mode_q == MODE_POST;
		end
	end

	// conversion sequencer; new triggers ignored while busy
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			busy_q <= 1'b0;
			convCnt_q <= 16'h0000;
			convChan_q <= 5'h00;
			trig_q <= 1'b0;
			result_q <= 16'h0000;
		end
		else
		begin
			trig_q <= trigNow && !busy_q;
			if (trigNow && !busy_q)
			begin
				busy_q <= 1'b1;
				convCnt_q <= 16'h0000;
				convChan_q <= chanEff;
			end
			else if (convDone)
			begin
				busy_q <= 1'b0;
				result_q <= {convChan_q[TAG_BITS-1:0], adcData};
			end
			else if (busy_q)
				convCnt_q <= convCnt_q + 16'h0001;
		end
	end

	// add-on request: set wins over the clear read
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			addonIrq_q <= 1'b0;
		else if (srcEvent)
			addonIrq_q <= 1'b1;
		else if (rdHit && bus.addr == OFS_TRIG_CLR)
			addonIrq_q <= 1'b0;
	end

	// read data, one cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			rdata_q <= 32'h0000_0000;
		else if (!rdHit)
			rdata_q <= 32'h0000_0000;
		else if (bus.addr == OFS_BRIDGE_IRQ)
		begin
			rdata_q <= bic_q | (32'(addonIrq_q) << BIC_FLAG_BIT);
		end
		else if (bus.addr == OFS_CHAN_STATUS)
			rdata_q <= {24'h0, status};
		else if (bus.addr == OFS_DIGIO)
			rdata_q <= {16'h0, digIn};
		else if (bus.addr == OFS_RESULT)
			rdata_q <= {16'h0, result_q};
		else
			rdata_q <= 32'h0000_0000;
	end

	// pci interrupt pin and timer chip passthrough
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			irqOut_q <= 1'b1;
			tAddr_q <= 8'h00;
			tData_q <= 8'h00;
			tWr_q <= 1'b0;
		end
		else
		begin
			irqOut_q <= ~(addonIrq_q & bic_q[BIC_ENABLE_BIT]);
			tWr_q <= wrHit && bus.addr <= OFS_TIMER_MODE;
			tAddr_q <= bus.addr;
			tData_q <= bus.wdata[7:0];
		end
	end

	assign bus.rdata = rdata_q;
	assign bus.irqOut_b = irqOut_q;
	assign digOut = dout_q;
	assign chanSel = chan_q;
	assign gainSel = gain_q;
	assign convStart = trig_q;
	assign tmr1Gate = gate_q;
	assign timerAddr = tAddr_q;
	assign timerWdata = tData_q;
	assign timerWr = tWr_q;
endmodule

// ---- logic/dac_pkg.sv ----
package dac_pkg;
	// register byte offsets on the board's i/o space
	localparam logic [7:0] OFS_TIMER0 = 8'h00;
	localparam logic [7:0] OFS_TIMER1 = 8'h04;
	localparam logic [7:0] OFS_TIMER2 = 8'h08;
	localparam logic [7:0] OFS_TIMER_MODE = 8'h0C;
	localparam logic [7:0] OFS_CHAN_STATUS = 8'h10;
	localparam logic [7:0] OFS_GAIN = 8'h14;
	localparam logic [7:0] OFS_GEN_CTRL = 8'h18;
	localparam logic [7:0] OFS_TRIG_CLR = 8'h1C;
	localparam logic [7:0] OFS_DIGIO = 8'h20;
	localparam logic [7:0] OFS_RESULT = 8'h30;
	localparam logic [7:0] OFS_BRIDGE_IRQ = 8'h4C;
	// bridge interrupt control fields
	localparam int BIC_ENABLE_BIT = 6;
	localparam int BIC_FLAG_BIT = 2;
	localparam logic [31:0] BIC_RESET = 32'h0000_0003;
	localparam logic [31:0] BIC_ENABLE_WORD = 32'h0000_0043;
	localparam logic [31:0] BIC_DISABLE_WORD = 32'h0000_0003;
	// status fields
	localparam int ST_GAIN_LSB = 6;
	localparam int ST_TMR1_BIT = 5;
	localparam int ST_TMR0_BIT = 4;
	localparam int ST_TMR2_BIT = 3;
	localparam int ST_SINGLE_BIT = 1;
	localparam int ST_IDLE_BIT = 0;
	// general control fields
	localparam int GC_SRC_LSB = 2;
	localparam int GC_MODE_LSB = 0;
	localparam logic [2:0] SRC_NONE = 3'h0;
	localparam logic [2:0] SRC_CONV = 3'h1;
	localparam logic [2:0] SRC_TMR0 = 3'h2;
	localparam logic [2:0] SRC_EXT = 3'h3;
	localparam logic [2:0] SRC_TMR1 = 3'h4;
	localparam logic [1:0] MODE_GENERAL = 2'h0;
	localparam logic [1:0] MODE_EXTERNAL = 2'h1;
	localparam logic [1:0] MODE_PRE = 2'h2;
	localparam logic [1:0] MODE_POST = 2'h3;
	// result tag and data widths
	localparam int RES_BITS = 12;
	localparam int TAG_BITS = 4;
	// converter time in ns and host command port offsets
	localparam int CONV_TIME_NS = 8000;
	localparam int CLK_PERIOD_NS = 50;
	localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam logic [3:0] CMD_ADDR = 4'h0;
	localparam logic [3:0] CMD_WDATA = 4'h1;
	localparam logic [3:0] CMD_GO = 4'h2;
	localparam logic [3:0] CMD_STATUS = 4'h3;
	localparam logic [3:0] CMD_RDATA = 4'h4;
	localparam logic [1:0] GO_WRITE = 2'h1;
	localparam logic [1:0] GO_READ = 2'h2;
endpackage

// ---- logic/dac_io_if.sv ----
`timescale 1ns/1ps
interface dac_io_if;
	logic [7:0] addr; // byte offset
	logic [31:0] wdata; // host write data
	logic wr; // one-cycle write strobe
	logic rd; // one-cycle read strobe
	logic [31:0] rdata; // read data, valid the cycle after rd
	logic irqOut_b; // pci interrupt, active low
	modport device (input addr, wdata, wr, rd, output rdata, irqOut_b);
	modport host (output addr, wdata, wr, rd, input rdata, irqOut_b);
endinterface

// ---- logic/dac_fall_det.sv ----
`timescale 1ns/1ps
// registers a level and flags its falling edge in the same cycle the low level arrives
module dac_fall_det
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic level,
	output logic fall
);
	logic prev_q; // previous sample

	// remember last level; reset high so no false edge at release
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			prev_q <= 1'b1;
		else
			prev_q <= level;
	end

	assign fall = prev_q & ~level;
endmodule

// ---- logic/dac_host.sv ----
`timescale 1ns/1ps
// host-side bus master driven by a small command register file
module dac_host
	import dac_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	dac_io_if.host bus,
	input wire logic [3:0] cmdAddr,
	input wire logic [31:0] cmdWdata,
	input wire logic cmdWr,
	input wire logic cmdRd,
	output logic [31:0] cmdRdata,
	output logic irqSeen
);
	typedef enum logic [1:0] {IDLE, WAIT_RD, DONE} dac_hst_type;
	dac_hst_type state_q; // transfer state
	logic [7:0] addr_q; // target offset
	logic [31:0] wdata_q; // write data
	logic [31:0] rdat_q; // captured read data
	logic wr_q, rd_q; // strobes to device
	logic [31:0] cmdR_q; // command read data
	logic irq_q; // registered interrupt

	// software writes targets; GO launches one bus access
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_q <= IDLE;
			addr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			rdat_q <= 32'h0000_0000;
			wr_q <= 1'b0;
			rd_q <= 1'b0;
		end
		else
		begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			case (state_q)
				IDLE:
				begin
					if (cmdWr && cmdAddr == CMD_ADDR)
						addr_q <= cmdWdata[7:0];
					else if (cmdWr && cmdAddr == CMD_WDATA)
						// bridge writes keep bits 1:0 set
						wdata_q <= (addr_q == OFS_BRIDGE_IRQ) ?
							(cmdWdata | 32'h0000_0003) : cmdWdata;
					else if (cmdWr && cmdAddr == CMD_GO)
					begin
						wr_q <= cmdWdata[1:0] == GO_WRITE;
						rd_q <= cmdWdata[1:0] == GO_READ;
						if (cmdWdata[1:0] == GO_READ)
							state_q <= WAIT_RD;
					end
				end
				WAIT_RD: state_q <= DONE;
				DONE:
				begin
					rdat_q <= bus.rdata;
					state_q <= IDLE;
				end
				default: state_q <= IDLE;
			endcase
		end
	end

	// command read port, one cycle latency
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cmdR_q <= 32'h0000_0000;
			irq_q <= 1'b0;
		end
		else
		begin
			irq_q <= ~bus.irqOut_b;
			if (cmdRd && cmdAddr == CMD_STATUS)
				cmdR_q <= {30'h0, irq_q, state_q != IDLE};
			else if (cmdRd && cmdAddr == CMD_RDATA)
				cmdR_q <= rdat_q;
			else
				cmdR_q <= 32'h0000_0000;
		end
	end

	assign bus.addr = addr_q;
	assign bus.wdata = wdata_q;
	assign bus.wr = wr_q;
	assign bus.rd = rd_q;
	assign cmdRdata = cmdR_q;
	assign irqSeen = irq_q;
endmodule

// ---- test/dac_bus_props.sv ----
`timescale 1ns/1ps
// watches the bus that joins host and device
module dac_bus_props
	import dac_pkg::*;
#(
	parameter int CONV_CYC = CONV_CYCLES
)
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	input wire logic irqOut_b
);
	// slack covers strobe latency plus irq register stages
	localparam int LATE = CONV_CYC + 12;
	logic enQ; // bridge enable as last written
	logic [1:0] gainQ; // gain code as last written
	logic [2:0] srcQ; // irq source as last written
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// shadow copies of host-written fields
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			enQ <= 1'b0;
			gainQ <= 2'h0;
			srcQ <= SRC_NONE;
		end
		else if (wr)
		begin
			if (addr == OFS_BRIDGE_IRQ)
				enQ <= wdata[BIC_ENABLE_BIT];
			if (addr == OFS_GAIN)
				gainQ <= wdata[1:0];
			if (addr == OFS_GEN_CTRL)
				srcQ <= wdata[4:2];
		end
	end
	sequence swTrig;
		wr && addr == OFS_TRIG_CLR;
	endsequence
	sequence readAt(logic [7:0] ofs);
		rd && addr == ofs;
	endsequence
	irq_gate_a: assert property (!irqOut_b |-> $past(enQ))
		else $error("pci interrupt low while disabled");
	bic_read_a: assert property (readAt(OFS_BRIDGE_IRQ) |=>
		rdata[31:7] == 0 && rdata[6] == enQ && rdata[1:0] == 2'h3)
		else $error("bridge register readback wrong");
	host_ones_a: assert property (wr && addr == OFS_BRIDGE_IRQ
		|-> wdata[1:0] == 2'h3)
		else $error("bridge write without low bits set");
	gain_stat_a: assert property (readAt(OFS_CHAN_STATUS) |=>
		rdata[7:6] == gainQ && rdata[31:8] == 0)
		else $error("status gain field wrong");
	buf_width_a: assert property (readAt(OFS_RESULT) |=>
		rdata[31:16] == 0)
		else $error("result read has stray upper bits");
	busy_after_a: assert property (swTrig ##[1:12]
		readAt(OFS_CHAN_STATUS) |=> !rdata[0])
		else $error("status idle right after trigger");
	clear_irq_a: assert property (readAt(OFS_TRIG_CLR)
		|-> ##[1:3] irqOut_b)
		else $error("interrupt not cleared by read");
	conv_irq_a: assert property (swTrig
		and (srcQ == SRC_CONV && enQ) |-> ##[1:LATE] !irqOut_b)
		else $error("no interrupt after conversion");
endmodule

// ---- test/daq_board_acq_control_regs_tb.sv ----
`timescale 1ns/1ps
// host command port driven here; device pins modelled inline
module daq_board_acq_control_regs_tb
	import dac_pkg::*;
;
	localparam int CONV = 40; // short conversion keeps the run brief
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [2:0] fallIn = 3'h7; // ext, timer 0, timer 1 lines
	logic [15:0] digIn = 16'h3C5A;
	logic single = 1'b1; // input-type jumper, 1 single-ended
	logic [3:0] cmdAddr = 4'h0;
	logic [31:0] cmdWdata = 32'h0;
	logic cmdWr = 1'b0;
	logic cmdRd = 1'b0;
	logic [31:0] cmdRdata;
	logic irqSeen;
	logic [15:0] digOut;
	logic [4:0] chanSel;
	logic [1:0] gainSel;
	logic convStart;
	logic tmr1Gate;
	logic [31:0] v;
	logic [2:0] srcTab [3] = '{SRC_EXT, SRC_TMR0, SRC_TMR1};
	int n_errors = 0;
	int num_checks = 0;
	int nConv = 0;
	dac_io_if ioBus();
	always #25 clk = ~clk;
	// count conversion start pulses
	always @(posedge clk)
		if (convStart === 1'b1)
			nConv <= nConv + 1;
	dac_device #(.CONV_CYC(CONV)) u_dac_device (.clk(clk), .rst_b(rst_b),
		.bus(ioBus), .singleEnded(single), .extTrig(fallIn[0]),
		.tmr0Out(fallIn[1]), .tmr1Out(fallIn[2]), .tmr2Out(1'b0),
		.testBit(1'b1), .digIn(digIn), .adcData(12'hABC),
		.digOut(digOut), .chanSel(chanSel), .gainSel(gainSel),
		.convStart(convStart), .tmr1Gate(tmr1Gate), .timerAddr(),
		.timerWdata(), .timerWr());
	dac_host u_dac_host (.clk(clk), .rst_b(rst_b), .bus(ioBus),
		.cmdAddr(cmdAddr), .cmdWdata(cmdWdata), .cmdWr(cmdWr),
		.cmdRd(cmdRd), .cmdRdata(cmdRdata), .irqSeen(irqSeen));
	dac_bus_props #(.CONV_CYC(CONV)) u_dac_bus_props (.clk(clk),
		.rst_b(rst_b), .addr(ioBus.addr), .wdata(ioBus.wdata),
		.wr(ioBus.wr), .rd(ioBus.rd), .rdata(ioBus.rdata),
		.irqOut_b(ioBus.irqOut_b));
	task wrap_up;
		$display("errors=%0d checks=%0d", n_errors, num_checks);
		if (n_errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one command strobe; a gap cycle follows so strobes never merge
	task cw(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		cmdAddr <= a;
		cmdWdata <= d;
		cmdWr <= 1'b1;
		@(posedge clk);
		cmdWr <= 1'b0;
	endtask
	task wrR(input logic [7:0] o, input logic [31:0] d);
		cw(CMD_ADDR, {24'h0, o});
		cw(CMD_WDATA, d);
		cw(CMD_GO, {30'h0, GO_WRITE});
		repeat (2) @(posedge clk);
	endtask
	// bus read lands two cycles after the strobe, then fetch it
	task rdR(input logic [7:0] o, output logic [31:0] q);
		cw(CMD_ADDR, {24'h0, o});
		cw(CMD_GO, {30'h0, GO_READ});
		repeat (3) @(posedge clk);
		@(posedge clk);
		cmdAddr <= CMD_RDATA;
		cmdRd <= 1'b1;
		@(posedge clk);
		cmdRd <= 1'b0;
		#1 q = cmdRdata;
	endtask
	task rdChk(input logic [7:0] o, input logic [31:0] e);
		rdR(o, v);
		chk(v, e);
	endtask
	// bounded wait; a timeout is a mismatch and ends the run
	task waitIrq(input logic e);
		for (int i = 0; i < 200 && irqSeen !== e; i++)
			@(posedge clk);
		chk({31'h0, irqSeen}, {31'h0, e});
		if (irqSeen !== e)
			wrap_up();
	endtask
	// falling pulse of 100 ns, over the minimum width
	task pulse(input int k);
		@(posedge clk);
		fallIn[k] <= 1'b0;
		repeat (2) @(posedge clk);
		fallIn[k] <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
	endtask
	initial
	begin
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		rdChk(OFS_BRIDGE_IRQ, 32'h3);
		rdChk(OFS_CHAN_STATUS, 32'h37);
		chk({25'h0, gainSel, chanSel}, 32'h0);
		// low bits left clear: the host must force them
		wrR(OFS_BRIDGE_IRQ, 32'h40);
		wrR(OFS_TRIG_CLR, 32'h0);
		rdR(OFS_CHAN_STATUS, v);
		chk({31'h0, v[0]}, 32'h0);
		// pacing gap before the next trigger
		repeat (CONV + 10) @(posedge clk);
		chk(32'(nConv), 32'h1);
		rdChk(OFS_BRIDGE_IRQ, 32'h43);
		rdChk(OFS_CHAN_STATUS, 32'h37);
		wrR(OFS_DIGIO, 32'hFFFF_A5C3);
		chk({16'h0, digOut}, 32'hA5C3);
		rdChk(OFS_DIGIO, 32'h3C5A);
		// stray high bits must not reach the gain code
		for (int g = 0; g < 4; g++)
		begin
			wrR(OFS_GAIN, 32'hFC | g);
			rdChk(OFS_CHAN_STATUS, 32'h37 | (g << 6));
		end
		wrR(OFS_CHAN_STATUS, 32'hF7);
		chk({27'h0, chanSel}, 32'h17);
		wrR(OFS_GEN_CTRL, {27'h0, SRC_CONV, MODE_GENERAL});
		wrR(OFS_TRIG_CLR, 32'h0);
		// second trigger lands while busy and is dropped
		wrR(OFS_TRIG_CLR, 32'h5A);
		waitIrq(1'b1);
		chk(32'(nConv), 32'h2);
		rdChk(OFS_RESULT, 32'h7ABC);
		rdChk(OFS_BRIDGE_IRQ, 32'h47);
		rdR(OFS_TRIG_CLR, v);
		waitIrq(1'b0);
		rdChk(OFS_BRIDGE_IRQ, 32'h43);
		// each edge source in turn; only timer 0 also converts
		// no software trigger while timer 0 pulses
		for (int k = 0; k < 3; k++)
		begin
			wrR(OFS_GEN_CTRL, {27'h0, srcTab[k], MODE_GENERAL});
			pulse(k);
			waitIrq(1'b1);
			rdR(OFS_TRIG_CLR, v);
			waitIrq(1'b0);
		end
		chk(32'(nConv), 32'h3);
		wrR(OFS_BRIDGE_IRQ, BIC_DISABLE_WORD);
		pulse(2);
		rdChk(OFS_BRIDGE_IRQ, 32'h7);
		chk({31'h0, irqSeen}, 32'h0);
		rdR(OFS_TRIG_CLR, v);
		wrR(OFS_BRIDGE_IRQ, BIC_ENABLE_WORD);
		// unused source code: edges convert but never interrupt
		wrR(OFS_GEN_CTRL, {27'h0, 3'h7, MODE_EXTERNAL});
		repeat (2)
		begin
			pulse(0);
			repeat (CONV + 4) @(posedge clk);
		end
		chk(32'(nConv), 32'h5);
		rdChk(OFS_BRIDGE_IRQ, 32'h43);
		wrR(OFS_GEN_CTRL, {27'h0, SRC_NONE, MODE_PRE});
		chk({31'h0, tmr1Gate}, 32'h1);
		pulse(2);
		chk(32'(nConv), 32'h6);
		pulse(0);
		chk({31'h0, tmr1Gate}, 32'h0);
		repeat (CONV) @(posedge clk);
		wrR(OFS_GEN_CTRL, {27'h0, SRC_NONE, MODE_POST});
		chk({31'h0, tmr1Gate}, 32'h0);
		pulse(0);
		chk({31'h0, tmr1Gate}, 32'h1);
		// jumper moved to differential: status bit 1 drops
		@(posedge clk);
		single <= 1'b0;
		rdChk(OFS_CHAN_STATUS, 32'hF5);
		wrap_up();
	end
endmodule
